//--- rtl/dcf_fifo.sv
// Behaviour
// - Enable pin high at reset: second write enable
// - Enable pin low at reset: offset load control; here load low only blocks writes, offsets are set over the bus
// - Dual mode writes need enable A low, B high
// - No write stored while full flag low
// - Both read enables low advance read side
// - No read while empty flag low
// - Output enable low drives data bus
// - Empty flag low when nothing stored
// - Almost-empty low within offset, default seven
// - Almost-full low within offset, default seven
// - Full flag low when all locations used
// - Nine-bit parallel read data output
// - Reset clears pointers, sets reset flag levels
// - Flag mode: enable A low with load high qualifies writes
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module dcf_fifo (
  input  wire logic                 I_SYS_CLK,
  input  wire logic                 I_RST_N,
  input  wire logic [8:0]           I_WRITE_DATA,
  input  wire logic                 I_WRITE_ENABLE_A_N,
  input  wire logic                 I_SECOND_ENABLE_OR_LOAD_N,
  input  wire logic                 I_READ_ENABLE_A_N,
  input  wire logic                 I_READ_ENABLE_B_N,
  input  wire logic                 I_OUTPUT_ENABLE_N,
  input  wire dcf_pkg::dcf_wb_req_t I_WB_REQ,
  output logic      [31:0]          O_WB_DAT,
  output logic                      O_WB_ACK,
  output logic      [8:0]           O_READ_DATA_OUT,
  output logic                      O_READ_DATA_OE,
  output logic                      O_EMPTY_FLAG_N,
  output logic                      O_FULL_FLAG_N,
  output logic                      O_ALMOST_EMPTY_FLAG_N,
  output logic                      O_ALMOST_FULL_FLAG_N,
  output logic                      O_IRQ
);

  dcf_pkg::dcf_mode_t  mode;
  dcf_pkg::dcf_flags_t flags, next_flags;
  logic [8:0]          mem [64];
  logic [6:0]          wr_ptr, rd_ptr;
  logic [6:0]          wr_gray, rd_gray;
  logic [6:0]          wr_gray_s, rd_gray_s;
  logic [6:0]          wr_bin_s, rd_bin_s;
  logic [6:0]          next_wr_ptr, next_rd_ptr;
  logic [6:0]          next_wcount, next_rcount;
  logic [6:0]          empty_ofs, full_ofs;
  logic [5:0]          irq_status, irq_mask;
  logic [5:0]          irq_event, next_irq_status;
  logic [31:0]         rd_word;
  logic                wr_qual, rd_qual;
  logic                wr_do, rd_do;
  logic                bus_req, bus_wr;

  function automatic logic [6:0] from_gray(input logic [6:0] g);
    logic [6:0] b;
    b[6] = g[6];
    for (int i = 5; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    from_gray = b;
  endfunction

  // Strap caught on the first edge after release, never under reset
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      mode <= dcf_pkg::MODE_PENDING;
    else
    begin
      case (mode)
        dcf_pkg::MODE_PENDING:
          mode <= I_SECOND_ENABLE_OR_LOAD_N ? dcf_pkg::MODE_DUAL
                                            : dcf_pkg::MODE_FLAG;
        dcf_pkg::MODE_DUAL, dcf_pkg::MODE_FLAG: mode <= mode;  // Held until next reset
        default:               mode <= dcf_pkg::MODE_PENDING;
      endcase
    end
  end

  // Write qualification; load low in flag mode blocks the data write and loads no offset
  always_comb
  begin
    case (mode)
      dcf_pkg::MODE_DUAL:
        wr_qual = !I_WRITE_ENABLE_A_N && I_SECOND_ENABLE_OR_LOAD_N;
      dcf_pkg::MODE_FLAG:
        wr_qual = !I_WRITE_ENABLE_A_N && I_SECOND_ENABLE_OR_LOAD_N;
      default:
        wr_qual = 1'b0;
    endcase
  end

  // Requests gated by the registered flags of each side
  assign wr_do       = wr_qual && flags.full_n;
  assign rd_qual     = !I_READ_ENABLE_A_N && !I_READ_ENABLE_B_N;
  assign rd_do       = rd_qual && flags.empty_n;
  assign next_wr_ptr = wr_do ? 7'(wr_ptr + dcf_pkg::PTR_ONE) : wr_ptr;
  assign next_rd_ptr = rd_do ? 7'(rd_ptr + dcf_pkg::PTR_ONE) : rd_ptr;

  // Write pointer and its gray copy move together
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      wr_ptr  <= dcf_pkg::PTR_ZERO;
      wr_gray <= dcf_pkg::PTR_ZERO;
    end
    else
    begin
      wr_ptr  <= next_wr_ptr;
      wr_gray <= next_wr_ptr ^ (next_wr_ptr >> 1);
    end
  end

  // Read pointer and its gray copy
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rd_ptr  <= dcf_pkg::PTR_ZERO;
      rd_gray <= dcf_pkg::PTR_ZERO;
    end
    else
    begin
      rd_ptr  <= next_rd_ptr;
      rd_gray <= next_rd_ptr ^ (next_rd_ptr >> 1);
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge I_SYS_CLK)
  begin
    if (wr_do)
      mem[wr_ptr[5:0]] <= I_WRITE_DATA;
  end

  // Gray pointers cross so that a part in flight is off by at most one
  dcf_sync2 #(.W(dcf_pkg::PTR_W)) u_wr_to_rd (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_d     (wr_gray),
    .o_q     (wr_gray_s)
  );
  dcf_sync2 #(.W(dcf_pkg::PTR_W)) u_rd_to_wr (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_d     (rd_gray),
    .o_q     (rd_gray_s)
  );

  // Counts against the stale far pointer err toward full and empty
  assign wr_bin_s    = from_gray(wr_gray_s);
  assign rd_bin_s    = from_gray(rd_gray_s);
  assign next_wcount = 7'(next_wr_ptr - rd_bin_s);
  assign next_rcount = 7'(wr_bin_s - next_rd_ptr);

  always_comb
  begin
    next_flags.full_n         = next_wcount != dcf_pkg::DEPTH;
    next_flags.almost_full_n  = next_wcount < 7'(dcf_pkg::DEPTH - full_ofs);
    next_flags.empty_n        = next_rcount != dcf_pkg::PTR_ZERO;
    next_flags.almost_empty_n = next_rcount > empty_ofs;
  end

  // Flags registered so the pins never glitch
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      flags <= '{empty_n: 1'b0, full_n: 1'b1, almost_empty_n: 1'b0, almost_full_n: 1'b1};
    else
      flags <= next_flags;
  end

  assign O_EMPTY_FLAG_N        = flags.empty_n;
  assign O_FULL_FLAG_N         = flags.full_n;
  assign O_ALMOST_EMPTY_FLAG_N = flags.almost_empty_n;
  assign O_ALMOST_FULL_FLAG_N  = flags.almost_full_n;

  // Read data and its enable, both from flops
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_READ_DATA_OUT <= dcf_pkg::DATA_RESET;
      O_READ_DATA_OE  <= 1'b0;
    end
    else
    begin
      if (rd_do)
        O_READ_DATA_OUT <= mem[rd_ptr[5:0]];
      O_READ_DATA_OE <= !I_OUTPUT_ENABLE_N;
    end
  end

  // Interrupt events: flags falling, refused requests
  always_comb
  begin
    irq_event                          = dcf_pkg::IRQ_RESET;
    irq_event[dcf_pkg::IRQ_EMPTY]      = flags.empty_n && !next_flags.empty_n;
    irq_event[dcf_pkg::IRQ_FULL]       = flags.full_n && !next_flags.full_n;
    irq_event[dcf_pkg::IRQ_AEMPTY]     = flags.almost_empty_n && !next_flags.almost_empty_n;
    irq_event[dcf_pkg::IRQ_AFULL]      = flags.almost_full_n && !next_flags.almost_full_n;
    irq_event[dcf_pkg::IRQ_WR_REFUSED] = wr_qual && !flags.full_n;
    irq_event[dcf_pkg::IRQ_RD_REFUSED] = rd_qual && !flags.empty_n;
  end

  // Single-cycle classic slave; write lands on the acked edge
  assign bus_req = I_WB_REQ.cyc && I_WB_REQ.stb;
  assign bus_wr  = bus_req && I_WB_REQ.we && O_WB_ACK && I_WB_REQ.sel[0];

  // Write-one-to-clear, a new event wins over the clear
  always_comb
  begin
    next_irq_status = irq_status;
    if (bus_wr && I_WB_REQ.adr == dcf_pkg::ADR_IRQ_STATUS)
      next_irq_status = irq_status & ~I_WB_REQ.dat[5:0];
    next_irq_status = next_irq_status | irq_event;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      irq_status <= dcf_pkg::IRQ_RESET;
      O_IRQ      <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      O_IRQ      <= |(irq_status & irq_mask);
    end
  end

  // Software registers: offsets default to seven
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      empty_ofs <= dcf_pkg::OFFSET_RESET;
      full_ofs  <= dcf_pkg::OFFSET_RESET;
      irq_mask  <= dcf_pkg::IRQ_RESET;
    end
    else if (bus_wr)
    begin
      case (I_WB_REQ.adr)
        dcf_pkg::ADR_EMPTY_OFS: empty_ofs <= I_WB_REQ.dat[6:0];
        dcf_pkg::ADR_FULL_OFS:  full_ofs  <= I_WB_REQ.dat[6:0];
        dcf_pkg::ADR_IRQ_MASK:  irq_mask  <= I_WB_REQ.dat[5:0];
        default:                irq_mask  <= irq_mask;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero and still ack
  always_comb
  begin
    rd_word = dcf_pkg::WB_ZERO;
    case (I_WB_REQ.adr)
      dcf_pkg::ADR_STATUS:
      begin
        rd_word[dcf_pkg::ST_MODE_DUAL]  = mode == dcf_pkg::MODE_DUAL;
        rd_word[dcf_pkg::ST_MODE_VALID] = mode != dcf_pkg::MODE_PENDING;
        rd_word[dcf_pkg::ST_EMPTY_N]    = flags.empty_n;
        rd_word[dcf_pkg::ST_FULL_N]     = flags.full_n;
        rd_word[dcf_pkg::ST_AEMPTY_N]   = flags.almost_empty_n;
        rd_word[dcf_pkg::ST_AFULL_N]    = flags.almost_full_n;
      end
      dcf_pkg::ADR_EMPTY_OFS:  rd_word[6:0] = empty_ofs;
      dcf_pkg::ADR_FULL_OFS:   rd_word[6:0] = full_ofs;
      dcf_pkg::ADR_IRQ_STATUS: rd_word[5:0] = irq_status;
      dcf_pkg::ADR_IRQ_MASK:   rd_word[5:0] = irq_mask;
      dcf_pkg::ADR_LEVEL:      rd_word[6:0] = 7'(wr_ptr - rd_bin_s);
      default:                 rd_word = dcf_pkg::WB_ZERO;
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= dcf_pkg::WB_ZERO;
    end
    else
    begin
      O_WB_ACK <= bus_req && !O_WB_ACK;
      if (bus_req && !O_WB_ACK)
        O_WB_DAT <= rd_word;
    end
  end

  default clocking dcf_cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);

  AST_MODE_HELD: assert property (
    (mode != dcf_pkg::MODE_PENDING) |=> $stable(mode))
    else $error("Mode changed after it was caught");
  AST_DUAL_GATE: assert property (
    (mode == dcf_pkg::MODE_DUAL && (I_WRITE_ENABLE_A_N || !I_SECOND_ENABLE_OR_LOAD_N))
    |=> (wr_ptr == $past(wr_ptr)))
    else $error("Dual mode stored without both enables");
  AST_NO_WRITE_FULL: assert property (
    !O_FULL_FLAG_N |=> $stable(wr_ptr))
    else $error("Write stored while full");
  AST_READ_ADVANCE: assert property (
    (!I_READ_ENABLE_A_N && !I_READ_ENABLE_B_N && O_EMPTY_FLAG_N)
    |=> (rd_ptr == 7'($past(rd_ptr) + dcf_pkg::PTR_ONE)))
    else $error("Read did not advance");
  AST_NO_READ_EMPTY: assert property (
    !O_EMPTY_FLAG_N |=> $stable(rd_ptr) && $stable(O_READ_DATA_OUT))
    else $error("Read taken while empty");
  AST_OE_FOLLOW: assert property (
    $changed(I_OUTPUT_ENABLE_N) |=> (O_READ_DATA_OE == !$past(I_OUTPUT_ENABLE_N)))
    else $error("Output enable not followed");
  AST_EMPTY_CLEARS: assert property (
    wr_do |-> ##[1:4] O_EMPTY_FLAG_N)
    else $error("Empty flag stuck after write");
  AST_AEMPTY_SAFE: assert property (
    (O_ALMOST_EMPTY_FLAG_N && $stable(empty_ofs)) |-> (7'(wr_ptr - rd_ptr) > empty_ofs))
    else $error("Almost-empty high within offset");
  AST_AFULL_SAFE: assert property (
    (O_ALMOST_FULL_FLAG_N && $stable(full_ofs))
    |-> (7'(wr_ptr - rd_ptr) < 7'(dcf_pkg::DEPTH - full_ofs)))
    else $error("Almost-full high within offset");
  AST_NO_OVERFLOW: assert property (
    7'(wr_ptr - rd_ptr) <= dcf_pkg::DEPTH)
    else $error("Stored count above depth");
  AST_RESET_LEVELS: assert property (
    $rose(I_RST_N) |-> (O_FULL_FLAG_N && O_ALMOST_FULL_FLAG_N && !O_EMPTY_FLAG_N
                        && !O_ALMOST_EMPTY_FLAG_N && wr_ptr == dcf_pkg::PTR_ZERO))
    else $error("Reset levels wrong");
  AST_FLAG_WRITE: assert property (
    (mode == dcf_pkg::MODE_FLAG && !I_WRITE_ENABLE_A_N && I_SECOND_ENABLE_OR_LOAD_N
     && O_FULL_FLAG_N) |=> (wr_ptr == 7'($past(wr_ptr) + dcf_pkg::PTR_ONE)))
    else $error("Flag mode write not stored");
  AST_GRAY_STEP: assert property (
    ($countones(wr_gray ^ $past(wr_gray)) <= 1) && ($countones(rd_gray ^ $past(rd_gray)) <= 1))
    else $error("Gray pointer moved more than one bit");

endmodule

//--- rtl/dcf_pkg.sv
package dcf_pkg;

  // Storage geometry
  localparam int          DATA_W       = 9;
  localparam int          ADDR_W       = 6;
  localparam int          PTR_W        = 7;
  localparam logic [6:0]  DEPTH        = 7'h40;
  localparam logic [6:0]  PTR_ZERO     = 7'h00;
  localparam logic [6:0]  PTR_ONE      = 7'h01;
  localparam logic [6:0]  OFFSET_RESET = 7'h07;
  localparam logic [8:0]  DATA_RESET   = 9'h000;

  // Register bus byte addresses
  localparam int          WB_AW          = 8;
  localparam logic [7:0]  ADR_STATUS     = 8'h00;
  localparam logic [7:0]  ADR_EMPTY_OFS  = 8'h04;
  localparam logic [7:0]  ADR_FULL_OFS   = 8'h08;
  localparam logic [7:0]  ADR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0]  ADR_IRQ_MASK   = 8'h10;
  localparam logic [7:0]  ADR_LEVEL      = 8'h14;
  localparam logic [31:0] WB_ZERO        = 32'h0000_0000;

  // Interrupt status and mask layout
  localparam int          IRQ_W          = 6;
  localparam int          IRQ_EMPTY      = 0;
  localparam int          IRQ_FULL       = 1;
  localparam int          IRQ_AEMPTY     = 2;
  localparam int          IRQ_AFULL      = 3;
  localparam int          IRQ_WR_REFUSED = 4;
  localparam int          IRQ_RD_REFUSED = 5;
  localparam logic [5:0]  IRQ_RESET      = 6'h00;

  // Status register layout
  localparam int          ST_MODE_DUAL  = 0;
  localparam int          ST_MODE_VALID = 1;
  localparam int          ST_EMPTY_N    = 2;
  localparam int          ST_FULL_N     = 3;
  localparam int          ST_AEMPTY_N   = 4;
  localparam int          ST_AFULL_N    = 5;

  // Enable strap decoding, caught once after reset
  typedef enum logic [2:0]
  {
    MODE_PENDING = 3'h1,
    MODE_DUAL    = 3'h2,
    MODE_FLAG    = 3'h4
  } dcf_mode_t;

  typedef struct packed
  {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } dcf_wb_req_t;

  typedef struct packed
  {
    logic empty_n;
    logic full_n;
    logic almost_empty_n;
    logic almost_full_n;
  } dcf_flags_t;

endpackage

//--- rtl/dcf_sync2.sv
`timescale 1ns/1ps
module dcf_sync2 #(
  parameter int W = 7
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta <= '0;
      o_q  <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule

//--- verification/dcf_partner.sv
`timescale 1ns/1ps
// Writer and reader logic facing the data ports
module dcf_partner (
  input  wire logic       i_clk,
  input  wire logic       i_wr_go,
  input  wire logic       i_wr_b,
  input  wire logic [8:0] i_wr_data,
  input  wire logic       i_rd_go,
  output logic            o_write_enable_a_n,
  output logic            o_second_enable_or_load_n,
  output logic      [8:0] o_write_data,
  output logic            o_read_enable_a_n,
  output logic            o_read_enable_b_n
);
  logic [8:0] last_data = 9'h155;
  // Last word kept so idle data lines never repeat it
  always_ff @(posedge i_clk)
  begin
    if (i_wr_go)
      last_data <= i_wr_data;
  end
  // Enable A low with B high qualifies a write; B doubles as strap
  assign o_write_enable_a_n        = !i_wr_go;
  assign o_second_enable_or_load_n = i_wr_b;
  // Idle data lines show the inverse, so a stray capture is seen
  assign o_write_data              = i_wr_go ? i_wr_data : ~last_data;
  // Both read enables fall together
  assign o_read_enable_a_n         = !i_rd_go;
  assign o_read_enable_b_n         = !i_rd_go;
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                 clk;
  logic                 rst_n;
  logic                 oe_n;
  dcf_pkg::dcf_wb_req_t wb_req;
  logic                 wr_go;
  logic                 wr_b;
  logic [8:0]           wr_data;
  logic                 rd_go;
  logic                 rd_seen;
  logic                 wa_n;
  logic                 wb_n;
  logic [8:0]           wd;
  logic                 ra_n;
  logic                 rb_n;
  logic [31:0]          wb_dat;
  logic                 ack;
  logic [8:0]           q;
  logic                 q_oe;
  logic                 e_n;
  logic                 f_n;
  logic                 ae_n;
  logic                 af_n;
  logic                 irq;
  logic [8:0]           exp_q[$];
  logic [8:0]           last_word;
  logic [8:0]           wdat;
  logic [31:0]          rdat;
  int                   mismatches;
  int                   checked;
  int                   seed;
  int                   n;
  int                   i;
  int                   e_ofs;
  int                   f_ofs;

  dcf_partner far (.i_clk(clk), .i_wr_go(wr_go), .i_wr_b(wr_b), .i_wr_data(wr_data),
    .i_rd_go(rd_go), .o_write_enable_a_n(wa_n), .o_second_enable_or_load_n(wb_n),
    .o_write_data(wd), .o_read_enable_a_n(ra_n), .o_read_enable_b_n(rb_n));

  dcf_fifo dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_WRITE_DATA(wd),
    .I_WRITE_ENABLE_A_N(wa_n), .I_SECOND_ENABLE_OR_LOAD_N(wb_n), .I_READ_ENABLE_A_N(ra_n),
    .I_READ_ENABLE_B_N(rb_n), .I_OUTPUT_ENABLE_N(oe_n), .I_WB_REQ(wb_req), .O_WB_DAT(wb_dat),
    .O_WB_ACK(ack), .O_READ_DATA_OUT(q), .O_READ_DATA_OE(q_oe), .O_EMPTY_FLAG_N(e_n),
    .O_FULL_FLAG_N(f_n), .O_ALMOST_EMPTY_FLAG_N(ae_n), .O_ALMOST_FULL_FLAG_N(af_n),
    .O_IRQ(irq));

  // Free-running clock, 5 ns
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task close_out;
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Strap level is on the enable pin while reset is low
  task reset(input logic strap);
    @(posedge clk);
    rst_n <= 1'b0;
    wr_b  <= strap;
    n = 0;
    e_ofs = 7;
    f_ofs = 7;
    exp_q.delete();
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Classic cycle; the slave sets the pace, ack or the 20-edge bound ends a wait
  task wbc(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int k;
    @(posedge clk);
    wb_req <= {1'b1, 1'b1, we, adr, 4'hF, dat};
    for (k = 0; k < 20 && ack !== 1'b1; k++)
      @(posedge clk);
    if (ack !== 1'b1)
    begin
      check("bus ack", 32'h0, 32'h1);
      close_out();
    end
    else
    begin
      rdat = wb_dat;
      wb_req <= '0;
    end
  endtask

  // Back-to-back writes; a word is noted only if it should be kept
  task wr(input int cnt, input logic b);
    int k;
    @(posedge clk);
    wr_go <= 1'b1;
    wr_b  <= b;
    for (k = 0; k < cnt; k++)
    begin
      wdat = 9'($random(seed));
      wr_data <= wdat;
      if (b && n < 64)
      begin
        exp_q.push_back(wdat);
        n++;
      end
      @(posedge clk);
    end
    wr_go <= 1'b0;
  endtask

  task rd(input int cnt);
    @(posedge clk);
    rd_go <= 1'b1;
    repeat (cnt) @(posedge clk);
    rd_go <= 1'b0;
    n = (n > cnt) ? n - cnt : 0;
  endtask

  // Flags settle three edges after the pointer moves
  task flags;
    repeat (5) @(posedge clk);
    check("empty", e_n, n != 0);
    check("full", f_n, n != 64);
    check("almost empty", ae_n, n > e_ofs);
    check("almost full", af_n, n < 64 - f_ofs);
  endtask

  // Scoreboard side: a taken read shows its word one edge later
  always @(posedge clk)
  begin
    rd_seen <= rst_n && !ra_n && !rb_n && (e_n === 1'b1);
    if (rd_seen)
    begin
      if (exp_q.size() == 0)
        check("spare read", 32'h1, 32'h0);
      else
      begin
        last_word = exp_q.pop_front();
        check("read word", q, last_word);
      end
    end
  end

  initial
  begin
    seed = 32'h98D5570A;
    rst_n = 1'b0;
    oe_n = 1'b0;
    wb_req = '0;
    wr_go = 1'b0;
    wr_b = 1'b1;
    wr_data = 9'h000;
    rd_go = 1'b0;
    rd_seen = 1'b0;
    reset(1'b1);
    check("empty at reset", e_n, 1'b0);
    check("full at reset", f_n, 1'b1);
    check("almost empty at reset", ae_n, 1'b0);
    check("almost full at reset", af_n, 1'b1);
    wbc(1'b0, dcf_pkg::ADR_EMPTY_OFS, 32'h0);
    check("empty offset", rdat, 32'h7);
    wbc(1'b0, dcf_pkg::ADR_FULL_OFS, 32'h0);
    check("full offset", rdat, 32'h7);
    wbc(1'b0, 8'h20, 32'h0);
    check("unmapped", rdat, 32'h0);
    wbc(1'b0, dcf_pkg::ADR_STATUS, 32'h0);
    check("dual mode", rdat[1:0], 2'b11);
    $display("Test reset values done");
    // Enable B low must keep words out
    wr(3, 1'b0);
    flags();
    check("nothing kept", e_n, 1'b0);
    for (i = 0; i < 64; i++)
    begin
      wr(1, 1'b1);
      flags();
    end
    wbc(1'b0, dcf_pkg::ADR_LEVEL, 32'h0);
    check("level", rdat, 32'h40);
    wr(1, 1'b1);
    flags();
    wbc(1'b0, dcf_pkg::ADR_IRQ_STATUS, 32'h0);
    check("refused and full", rdat & 32'h12, 32'h12);
    wbc(1'b1, dcf_pkg::ADR_IRQ_MASK, 32'h10);
    repeat (2) @(posedge clk);
    check("irq raised", irq, 1'b1);
    wbc(1'b1, dcf_pkg::ADR_IRQ_STATUS, 32'h10);
    repeat (2) @(posedge clk);
    check("irq cleared", irq, 1'b0);
    $display("Test fill and interrupt done");
    oe_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("bus released", q_oe, 1'b0);
    oe_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("bus driven", q_oe, 1'b1);
    while (n > 0)
    begin
      rd(1);
      flags();
    end
    rd(1);
    flags();
    check("held word", q, last_word);
    wbc(1'b0, dcf_pkg::ADR_IRQ_STATUS, 32'h0);
    check("empty events", rdat & 32'h25, 32'h25);
    wr(5, 1'b1);
    flags();
    rd(5);
    flags();
    $display("Test drain and burst done");
    reset(1'b0);
    wbc(1'b0, dcf_pkg::ADR_STATUS, 32'h0);
    check("flag mode", rdat[1:0], 2'b10);
    wr(2, 1'b0);
    flags();
    check("load low keeps nothing", e_n, 1'b0);
    // Non-default offsets so both programmable flags move off seven
    wbc(1'b1, dcf_pkg::ADR_EMPTY_OFS, 32'h2);
    wbc(1'b1, dcf_pkg::ADR_FULL_OFS, 32'h3C);
    e_ofs = 2;
    f_ofs = 60;
    wbc(1'b0, dcf_pkg::ADR_FULL_OFS, 32'h0);
    check("full offset written", rdat, 32'h3C);
    wr(4, 1'b1);
    flags();
    check("enable A writes", e_n, 1'b1);
    rd(4);
    flags();
    $display("Test flag mode done");
    close_out();
  end
endmodule
